// ==== verilog/ppm_pin_mux.sv ====
/*
 Port pin function multiplexer for first-port pins 0..7 and second-port pins 0..3.
 Holds the port control bytes behind APB and routes each pad to plain I/O, a timer,
 clock, test-port or converter function. Assumes pad inputs already synchronous.
*/
// What this block does
// [R1] Select 0: plain I/O, direction sets in/out
// [R2] Reset clears select, direction, analog enable
// [R3] Port1 bit0: timer clock in or converter clock
// [R4] Port1 bits1-3: capture A in or compare out
// [R5] Port1 bit4 clock out, bits5-6 compare out
// [R6] Port1 bit7 drives compare channel 2
// [R7] Test port active: bits4-7 carry test signals
// [R8] Test logic governs bits4-7 direction then
// [R9] Port2 bit0 aux clock; bit2 capture B/compare0
// [R10] Port2 bit1: alternate clock in or clock out
// [R11] Port2 bit3: capture B1 in or compare1 out
// [R12] Analog enable makes port2 pin analog input
// [R13] Analog enable turns off output driver
// [R14] Analog enable turns off digital input buffer
// [R15] Test/analog first, then select, then I/O
`default_nettype none
module ppm_pin_mux (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire ppm_pkg::ppm_pins_t pad_in,
   output ppm_pkg::ppm_pins_t pad_out,
   output ppm_pkg::ppm_pins_t pad_oe,
   input wire logic test_port_active,
   input wire ppm_pkg::ppm_periph_out_t periph_out,
   output ppm_pkg::ppm_periph_in_t periph_in,
   output logic [3:0] converter_analog_select,
   output logic negative_external_reference
);
   ////////////////////////////////////////////////////////////////////////////////////////
   // Control registers.
   logic write_strobe;
   logic [7:0] port1_output_bits;
   logic [7:0] port1_direction_bits;
   logic [7:0] port1_function_select_bits;
   logic [3:0] port2_output_bits;
   logic [3:0] port2_direction_bits;
   logic [3:0] port2_function_select_bits;
   logic [3:0] converter_analog_enable_bits;
   logic [6:0] reg_write;
   logic [31:0] read_value;
   logic read_hit;
   logic [7:0] port1_input_view;
   logic [3:0] port2_input_view;

   // Write decode, one strobe per control byte.
   always_comb begin
      reg_write = 7'h00;
      if (write_strobe) begin
         reg_write[0] = paddr == ppm_pkg::port1_output_addr;
         reg_write[1] = paddr == ppm_pkg::port1_direction_addr;
         reg_write[2] = paddr == ppm_pkg::port1_select_addr;
         reg_write[3] = paddr == ppm_pkg::port2_output_addr;
         reg_write[4] = paddr == ppm_pkg::port2_direction_addr;
         reg_write[5] = paddr == ppm_pkg::port2_select_addr;
         reg_write[6] = paddr == ppm_pkg::analog_enable_addr;
      end
   end

   // All control bytes reset to the cleared default, so every pin is plain I/O input.
   ppm_ctrl_reg #(.width(8), .reset_value(ppm_pkg::port1_reset)) u_p1_out ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[0]),
      .write_data(pwdata[7:0]), .value(port1_output_bits));
   ppm_ctrl_reg #(.width(8), .reset_value(ppm_pkg::port1_reset)) u_p1_dir ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[1]),
      .write_data(pwdata[7:0]), .value(port1_direction_bits));
   ppm_ctrl_reg #(.width(8), .reset_value(ppm_pkg::port1_reset)) u_p1_sel ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[2]),
      .write_data(pwdata[7:0]), .value(port1_function_select_bits));
   ppm_ctrl_reg #(.width(4), .reset_value(ppm_pkg::port2_reset)) u_p2_out ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[3]),
      .write_data(pwdata[3:0]), .value(port2_output_bits));
   ppm_ctrl_reg #(.width(4), .reset_value(ppm_pkg::port2_reset)) u_p2_dir ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[4]),
      .write_data(pwdata[3:0]), .value(port2_direction_bits));
   ppm_ctrl_reg #(.width(4), .reset_value(ppm_pkg::port2_reset)) u_p2_sel ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[5]),
      .write_data(pwdata[3:0]), .value(port2_function_select_bits));
   ppm_ctrl_reg #(.width(4), .reset_value(ppm_pkg::port2_reset)) u_ae ( // [R2]
      .clock(clock), .reset(reset), .write_strobe(reg_write[6]),
      .write_data(pwdata[3:0]), .value(converter_analog_enable_bits));

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register read path.
   always_comb begin
      read_hit = 1'b1;
      read_value = 32'h0000_0000;
      case (paddr)
         ppm_pkg::port1_output_addr: read_value[7:0] = port1_output_bits;
         ppm_pkg::port1_direction_addr: read_value[7:0] = port1_direction_bits;
         ppm_pkg::port1_select_addr: read_value[7:0] = port1_function_select_bits;
         ppm_pkg::port2_output_addr: read_value[3:0] = port2_output_bits;
         ppm_pkg::port2_direction_addr: read_value[3:0] = port2_direction_bits;
         ppm_pkg::port2_select_addr: read_value[3:0] = port2_function_select_bits;
         ppm_pkg::analog_enable_addr: read_value[3:0] = converter_analog_enable_bits;
         ppm_pkg::port1_input_addr: read_value[7:0] = port1_input_view;
         ppm_pkg::port2_input_addr: read_value[3:0] = port2_input_view;
         ppm_pkg::pin_status_addr: begin
            read_value[ppm_pkg::status_test_port_bit] = test_port_active;
            read_value[ppm_pkg::status_analog_lsb +: 4] = converter_analog_enable_bits;
         end
         default: read_hit = 1'b0;
      endcase
   end

   ppm_apb_slave u_apb (
      .clock(clock),
      .reset(reset),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .read_value(read_value),
      .read_hit(read_hit),
      .write_strobe(write_strobe),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Per-pin output selection. Each pad gets a level and an enable, registered below.
   ppm_pkg::ppm_pins_t next_pad_out;
   ppm_pkg::ppm_pins_t next_pad_oe;
   ppm_pkg::ppm_periph_in_t next_periph_in;
   logic [7:0] next_p1_in;
   logic [3:0] next_p2_in;
   logic [7:0] p1_alt_out;
   logic [3:0] p2_alt_out;

   // Peripheral signal each pin drives when selected as output.
   always_comb begin
      p1_alt_out[0] = periph_out.converter_clock_out; // [R3]
      p1_alt_out[1] = periph_out.timer_compare_out_ch0; // [R4]
      p1_alt_out[2] = periph_out.timer_compare_out_ch1; // [R4]
      p1_alt_out[3] = periph_out.timer_compare_out_ch2; // [R4]
      p1_alt_out[4] = periph_out.subsystem_master_clock; // [R5]
      p1_alt_out[5] = periph_out.timer_compare_out_ch0; // [R5]
      p1_alt_out[6] = periph_out.timer_compare_out_ch1; // [R5]
      p1_alt_out[7] = periph_out.timer_compare_out_ch2; // [R6]
      p2_alt_out[0] = periph_out.auxiliary_clock; // [R9]
      p2_alt_out[1] = periph_out.subsystem_master_clock; // [R10]
      p2_alt_out[2] = periph_out.timer_compare_out_ch0; // [R9]
      p2_alt_out[3] = periph_out.timer_compare_out_ch1; // [R11]
   end

   // First port: test port owns bits 4..7 above everything; then select; then plain I/O.
   genvar i;
   generate
      for (i = 0; i < ppm_pkg::port1_width; i++) begin : g_p1
         always_comb begin
            if (test_port_active && i >= 4) begin // [R15]
               // The test access logic decides direction: only the data-out pin drives.
               next_pad_oe.port1[i] = (i == 7) ? periph_out.test_data_out_enable : 1'b0; // [R8]
               next_pad_out.port1[i] = (i == 7) ? periph_out.test_data_out : 1'b0; // [R7]
            end else if (port1_function_select_bits[i]) begin
               next_pad_oe.port1[i] = port1_direction_bits[i];
               next_pad_out.port1[i] = p1_alt_out[i];
            end else begin
               next_pad_oe.port1[i] = port1_direction_bits[i]; // [R1]
               next_pad_out.port1[i] = port1_output_bits[i]; // [R1]
            end
            next_p1_in[i] = pad_in.port1[i];
         end
      end
      // Second port: analog enable wins, kills both driver and input buffer.
      for (i = 0; i < ppm_pkg::port2_width; i++) begin : g_p2
         always_comb begin
            if (converter_analog_enable_bits[i]) begin // [R15]
               next_pad_oe.port2[i] = 1'b0; // [R13]
               next_pad_out.port2[i] = 1'b0; // [R13]
               next_p2_in[i] = ppm_pkg::disabled_input_value; // [R14]
            end else if (port2_function_select_bits[i]) begin
               next_pad_oe.port2[i] = port2_direction_bits[i];
               next_pad_out.port2[i] = p2_alt_out[i];
               next_p2_in[i] = pad_in.port2[i];
            end else begin
               next_pad_oe.port2[i] = port2_direction_bits[i]; // [R1]
               next_pad_out.port2[i] = port2_output_bits[i]; // [R1]
               next_p2_in[i] = pad_in.port2[i];
            end
         end
      end
   endgenerate

   // Peripheral inputs. An input not selected reads the fixed disabled value, so a
   // peripheral never sees a pad it does not own; this costs nothing and avoids glitches.
   always_comb begin
      logic p1_in_sel;
      p1_in_sel = 1'b0;
      next_periph_in = '0;
      p1_in_sel = port1_function_select_bits[0] & ~port1_direction_bits[0];
      next_periph_in.timer_external_clock_in = p1_in_sel & next_p1_in[0]; // [R3]
      next_periph_in.capture_in_a_ch0 =
         port1_function_select_bits[1] & ~port1_direction_bits[1] & next_p1_in[1]; // [R4]
      next_periph_in.capture_in_a_ch1 =
         port1_function_select_bits[2] & ~port1_direction_bits[2] & next_p1_in[2]; // [R4]
      next_periph_in.capture_in_a_ch2 =
         port1_function_select_bits[3] & ~port1_direction_bits[3] & next_p1_in[3]; // [R4]
      next_periph_in.timer_alternate_clock_in = port2_function_select_bits[1]
         & ~port2_direction_bits[1] & next_p2_in[1]; // [R10]
      next_periph_in.capture_in_b_ch0 = port2_function_select_bits[2]
         & ~port2_direction_bits[2] & next_p2_in[2]; // [R9]
      next_periph_in.capture_in_b_ch1 = port2_function_select_bits[3]
         & ~port2_direction_bits[3] & next_p2_in[3]; // [R11]
      next_periph_in.test_clock_in = test_port_active & next_p1_in[4]; // [R7]
      next_periph_in.test_mode_select_in = test_port_active & next_p1_in[5]; // [R7]
      next_periph_in.test_data_in = test_port_active & next_p1_in[6]; // [R7]
      next_periph_in.test_clock_input = test_port_active & next_p1_in[6]; // [R7]
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Output registers: every pad, peripheral and converter output comes from a flip-flop, one cycle after its cause.
   always_ff @(posedge clock) begin
      if (reset) begin
         pad_out <= '0;
         pad_oe <= '0;
         periph_in <= '0;
         port1_input_view <= 8'h00;
         port2_input_view <= 4'h0;
         converter_analog_select <= 4'h0;
         negative_external_reference <= 1'b0;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
         periph_in <= next_periph_in;
         port1_input_view <= next_p1_in;
         port2_input_view <= next_p2_in;
         converter_analog_select <= converter_analog_enable_bits; // [R12]
         negative_external_reference <= converter_analog_enable_bits[3]; // [R12]
      end
   end
endmodule
`default_nettype wire

// ==== verilog/ppm_pkg.sv ====
/*
 Package for the port pin function multiplexer: APB register map, field layouts, reset values
 and the packed structs that carry the pin and peripheral groups.
 Assumes a 32-bit APB master on the register side.
*/
`default_nettype none
package ppm_pkg;
   // Register byte addresses.
   localparam logic [7:0] port1_output_addr = 8'h00;
   localparam logic [7:0] port1_direction_addr = 8'h04;
   localparam logic [7:0] port1_select_addr = 8'h08;
   localparam logic [7:0] port2_output_addr = 8'h0c;
   localparam logic [7:0] port2_direction_addr = 8'h10;
   localparam logic [7:0] port2_select_addr = 8'h14;
   localparam logic [7:0] analog_enable_addr = 8'h18;
   localparam logic [7:0] port1_input_addr = 8'h1c;
   localparam logic [7:0] port2_input_addr = 8'h20;
   localparam logic [7:0] pin_status_addr = 8'h24;
   // Widths.
   localparam int port1_width = 8;
   localparam int port2_width = 4;
   // Reset values: everything cleared, so every pin is a plain input.
   localparam logic [7:0] port1_reset = 8'h00;
   localparam logic [3:0] port2_reset = 4'h0;
   // Value a digital read returns for a pin whose input buffer is off.
   localparam logic disabled_input_value = 1'b0;
   // Field positions in the pin status register.
   localparam int status_test_port_bit = 0;
   localparam int status_analog_lsb = 4;
   // Unmapped reads return this.
   localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

   // One bit per pad: eight first-port pins and four second-port pins.
   typedef struct packed {
      logic [7:0] port1;
      logic [3:0] port2;
   } ppm_pins_t;

   // Signals from peripherals that may drive pins.
   typedef struct packed {
      logic converter_clock_out;
      logic subsystem_master_clock;
      logic auxiliary_clock;
      logic timer_compare_out_ch0;
      logic timer_compare_out_ch1;
      logic timer_compare_out_ch2;
      logic test_data_out;
      logic test_data_out_enable;
   } ppm_periph_out_t;

   // Signals delivered to peripherals from pins.
   typedef struct packed {
      logic timer_external_clock_in;
      logic timer_alternate_clock_in;
      logic capture_in_a_ch0;
      logic capture_in_a_ch1;
      logic capture_in_a_ch2;
      logic capture_in_b_ch0;
      logic capture_in_b_ch1;
      logic test_clock_in;
      logic test_mode_select_in;
      logic test_data_in;
      logic test_clock_input;
   } ppm_periph_in_t;
endpackage
`default_nettype wire

// ==== verilog/ppm_ctrl_reg.sv ====
/*
 Generic resettable control register used for each port control byte.
 Assumes a synchronous active-high reset and a one-cycle write strobe.
*/
`default_nettype none
module ppm_ctrl_reg #(
   parameter int width = 8,
   parameter logic [width-1:0] reset_value = '0
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic write_strobe,
   input wire logic [width-1:0] write_data,
   output logic [width-1:0] value
);
   logic [width-1:0] next_value;

   // Software write replaces the byte; reset restores the cleared default.
   always_comb begin
      next_value = value;
      if (write_strobe) begin
         next_value = write_data;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         value <= reset_value;
      end else begin
         value <= next_value;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/ppm_apb_slave.sv ====
/*
 APB slave front end: decodes setup/access phases into a one-cycle write strobe and
 registers read data. Answers every access with zero wait states and pslverr on unmapped.
 Assumes the master holds the request stable through the access phase.
*/
`default_nettype none
module ppm_apb_slave (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] read_value,
   input wire logic read_hit,
   output logic write_strobe,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   logic access;
   logic [31:0] next_prdata;
   logic next_pslverr;

   // Access phase: ready is given in the first access cycle, so no wait states.
   assign access = psel & penable;
   assign write_strobe = access & pwrite;
   assign pready = 1'b1;

   // Read data is captured in the setup cycle so it is stable in the access cycle.
   always_comb begin
      next_prdata = prdata;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_prdata = read_hit ? read_value : ppm_pkg::unmapped_read_value;
         next_pslverr = !read_hit;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         prdata <= ppm_pkg::unmapped_read_value;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end
   // Ignore paddr here: decode of writes is done by the caller.
   logic unused_paddr;
   assign unused_paddr = ^paddr;
endmodule
`default_nettype wire

// ==== sim/ppm_periph_model.sv ====
/*
 Model of the peripherals behind the pin multiplexer: timer, clock system, converter, test port.
 Assumes the multiplexer's clock and synchronous reset.
*/
`default_nettype none
module ppm_periph_model (
   input wire logic clock,
   input wire logic reset,
   output ppm_pkg::ppm_periph_out_t periph_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] count;
   logic [7:0] next_count;
   // Free-running count; distinct bit rates let each source be told apart on a pad.
   always_comb begin
      next_count = count + 8'h01;
   end
   always_ff @(posedge clock) begin
      count <= reset ? 8'h00 : next_count;
   end
   // Clocks and compare units keep running, so a stuck route shows up quickly.
   assign periph_out = {count[0], count[1], count[7], count[2], count[3], count[4], count[5],
      count[6]};
endmodule
`default_nettype wire

// ==== sim/ppm_pin_mux_asserts.sv ====
/*
 Concurrent checks on the ports of the pin multiplexer.
 Assumes one clock domain and the bind at the foot of this file.
*/
`default_nettype none
module ppm_pin_mux_asserts (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire ppm_pkg::ppm_pins_t pad_in,
   input wire ppm_pkg::ppm_pins_t pad_out,
   input wire ppm_pkg::ppm_pins_t pad_oe,
   input wire logic test_port_active,
   input wire ppm_pkg::ppm_periph_out_t periph_out,
   input wire ppm_pkg::ppm_periph_in_t periph_in,
   input wire logic [3:0] converter_analog_select,
   input wire logic negative_external_reference
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   // Test port owning the upper pins during a cycle out of reset.
   sequence s_test_owned;
      !reset && test_port_active;
   endsequence
   ///////////////////////////////////////////////////////////////////////////
   // Reset must clear the pads whatever state the block was in.
   chk_reset_clears: assert property (disable iff (1'b0) reset |=>
      pad_oe == '0 && pad_out == '0 && periph_in == '0 && converter_analog_select == 4'h0)
      else $error("pads not cleared by reset");
   chk_test_inputs: assert property (s_test_owned |=>
      {periph_in.test_clock_input, periph_in.test_data_in, periph_in.test_mode_select_in,
      periph_in.test_clock_in} == {$past(pad_in.port1[6]), $past(pad_in.port1[6:4])})
      else $error("test inputs not routed");
   chk_test_drive: assert property (s_test_owned |=>
      pad_oe.port1[7:4] == {$past(periph_out.test_data_out_enable), 3'b000})
      else $error("test port does not own pin enables");
   chk_test_data: assert property (s_test_owned ##0 periph_out.test_data_out_enable |=>
      pad_out.port1[7] == $past(periph_out.test_data_out)) else $error("test data not driven");
   // The select copy and the pads leave the same flip-flop stage, so no lag is allowed.
   chk_analog_oe: assert property (
      (converter_analog_select & pad_oe.port2) == 4'h0)
      else $error("analog pin still driven");
   chk_analog_inputs: assert property (
      (converter_analog_select & {periph_in.capture_in_b_ch1,
      periph_in.capture_in_b_ch0, periph_in.timer_alternate_clock_in, 1'b0}) == 4'h0)
      else $error("analog pin input not blocked");
   chk_neg_ref: assert property (
      negative_external_reference == converter_analog_select[3]) else $error("reference wrong");
   chk_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
   chk_unmapped_err: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
      else $error("unmapped access not refused");
endmodule
bind ppm_pin_mux ppm_pin_mux_asserts i_ppm_pin_mux_asserts (.clock, .reset, .psel, .penable,
   .paddr, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .test_port_active, .periph_out,
   .periph_in, .converter_analog_select, .negative_external_reference);
`default_nettype wire

// ==== sim/tb_ppm_pin_mux.sv ====
/*
 Self-checking testbench for the pin multiplexer: APB master, pad stimulus, scenarios.
 Assumes the peripheral model and the bound checker.
*/
`default_nettype none
module tb_ppm_pin_mux;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, reset, psel, penable, pwrite, pready, pslverr, err, test_port_active;
   logic negative_external_reference;
   logic [7:0] paddr;
   logic [3:0] converter_analog_select;
   logic [31:0] pwdata, prdata, rd;
   ppm_pkg::ppm_pins_t pad_in, pad_out, pad_oe;
   ppm_pkg::ppm_periph_out_t periph_out, prev;
   ppm_pkg::ppm_periph_in_t periph_in;
   int errors, total_checks;
   ppm_pin_mux i_ppm_pin_mux (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .test_port_active, .periph_out, .periph_in,
      .converter_analog_select, .negative_external_reference);
   ppm_periph_model i_ppm_periph_model (.clock, .reset, .periph_out);
   // Free-running 100 MHz clock.
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   ///////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         complete_run();
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic setup(input logic [7:0] d1, s1, input logic [3:0] d2, s2, an);
      apb(1'b1, ppm_pkg::port1_direction_addr, {24'h0, d1});
      apb(1'b1, ppm_pkg::port1_select_addr, {24'h0, s1});
      apb(1'b1, ppm_pkg::port2_direction_addr, {28'h0, d2});
      apb(1'b1, ppm_pkg::port2_select_addr, {28'h0, s2});
      apb(1'b1, ppm_pkg::analog_enable_addr, {28'h0, an});
   endtask
   // Pads lag the sources by one edge, so the source value at that edge is kept.
   task automatic settle;
      repeat (2) @(posedge clock);
      prev = periph_out;
      #1;
   endtask
   function automatic logic [7:0] p1_exp(input ppm_pkg::ppm_periph_out_t p);
      return {p.timer_compare_out_ch2, p.timer_compare_out_ch1, p.timer_compare_out_ch0,
         p.subsystem_master_clock, p.timer_compare_out_ch2, p.timer_compare_out_ch1,
         p.timer_compare_out_ch0, p.converter_clock_out};
   endfunction
   ///////////////////////////////////////////////////////////////////////////
   task automatic t_reset_gpio;
      for (int a = 0; a <= 36; a += 4) begin
         rdchk(8'(a), (a == 28) ? 32'(pad_in.port1) :
            (a == 32) ? 32'(pad_in.port2) : 32'h0);
      end
      check(32'(pad_oe), 32'h0);
      apb(1'b1, ppm_pkg::port1_output_addr, 32'h000000a5);
      apb(1'b1, ppm_pkg::port2_output_addr, 32'h00000009);
      setup(8'hff, 8'h00, 4'hf, 4'h0, 4'h0);
      settle();
      check({pad_oe, pad_out}, 32'hfffa59);
      apb(1'b0, 8'h40, 32'h0);
      check(32'(err), 32'h1);
      check(rd, ppm_pkg::unmapped_read_value);
      $display("Test reset and plain I/O done");
   endtask
   task automatic t_alt;
      setup(8'hff, 8'hff, 4'hf, 4'hf, 4'h0);
      repeat (3) begin
         settle();
         check(32'(pad_out.port1), 32'(p1_exp(prev)));
         check(32'(pad_out.port2),
            {prev.timer_compare_out_ch1, prev.timer_compare_out_ch0,
            prev.subsystem_master_clock, prev.auxiliary_clock});
         check(32'(pad_oe), 32'hfff);
      end
      setup(8'h00, 8'hff, 4'h0, 4'hf, 4'h0);
      settle();
      check({periph_in.capture_in_a_ch2, periph_in.capture_in_a_ch1,
         periph_in.capture_in_a_ch0, periph_in.timer_external_clock_in}, pad_in.port1[3:0]);
      check({periph_in.capture_in_b_ch1, periph_in.capture_in_b_ch0,
         periph_in.timer_alternate_clock_in}, pad_in.port2[3:1]);
      $display("Test alternate functions done");
   endtask
   task automatic t_test_port;
      setup(8'hff, 8'hff, 4'h0, 4'h0, 4'h0);
      test_port_active <= 1'b1;
      repeat (40) begin
         settle();
         check(32'(pad_oe.port1[7:4]), {prev.test_data_out_enable, 3'b000});
         check(32'(pad_out.port1[3:0]), 32'(p1_exp(prev) & 8'h0f));
         if (prev.test_data_out_enable) begin
            check(32'(pad_out.port1[7]), 32'(prev.test_data_out));
         end
      end
      // Two complementary pad patterns, so a test input stuck at either level shows up.
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         pad_in <= {(k == 0) ? 8'ha5 : 8'h5a, 4'h6};
         settle();
         check({periph_in.test_clock_input, periph_in.test_data_in,
            periph_in.test_mode_select_in, periph_in.test_clock_in},
            {pad_in.port1[6], pad_in.port1[6:4]});
      end
      rdchk(ppm_pkg::pin_status_addr, 32'h1);
      test_port_active <= 1'b0;
      $display("Test port ownership done");
   endtask
   task automatic t_analog;
      setup(8'h00, 8'h00, 4'hf, 4'hf, 4'hf);
      settle();
      check({pad_oe.port2, converter_analog_select, negative_external_reference},
         9'h1f);
      setup(8'h00, 8'h00, 4'h0, 4'hf, 4'h5);
      settle();
      check({periph_in.capture_in_b_ch1, periph_in.capture_in_b_ch0,
         periph_in.timer_alternate_clock_in}, 3'b001);
      rdchk(ppm_pkg::port2_input_addr, 32'h2);
      rdchk(ppm_pkg::pin_status_addr, 32'h50);
      $display("Test analog enable done");
   endtask
   // A reset in mid-run, with controls still set, must bring every pin back to plain input.
   task automatic t_mid_reset;
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      check(32'({pad_oe, converter_analog_select}), 32'h0);
      for (int a = 0; a <= 24; a += 4) begin
         rdchk(8'(a), 32'h0);
      end
      $display("Test mid-run reset done");
   endtask
   // Main sequence.
   initial begin
      errors = 0;
      total_checks = 0;
      reset = 1'b1;
      {psel, penable, pwrite, test_port_active} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pad_in = {8'h5a, 4'h6};
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      t_reset_gpio();
      t_alt();
      t_test_port();
      t_analog();
      t_mid_reset();
      complete_run();
   end
endmodule
`default_nettype wire
